// [logic/ext_port_bank_decoder.sv]
// file: external port bank decoder with select, fetch window check and compressed unpacking
`timescale 1ns/1ps
module ext_port_bank_decoder #(
   parameter int unsigned NB = ext_port_pkg::NUM_BANKS,
   parameter int unsigned TW = ext_port_pkg::TIM_W
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // per-bank configuration plus shared sdram gap and mode, static while an access runs
   input wire logic [NB-1:0] i_bank_is_sdram,
   input wire logic [NB*2-1:0] i_bank_dev_width,
   input wire logic [NB*3-1:0] i_sdram_size,
   input wire logic [NB*TW-1:0] i_async_wait,
   input wire logic [TW-1:0] i_sdram_cmd_gap,
   input wire logic i_compressed_instruction_mode,
   // access request
   input wire logic i_req,
   input wire logic i_req_fetch,
   input wire logic [31:0] i_req_addr,
   // fetch data from memory
   input wire logic i_fetch_data_vld,
   input wire logic [47:0] i_fetch_data,
   // request answer
   output logic o_ack,
   output logic o_err,
   // external selects and address
   output logic [NB-1:0] o_bank_select_n,
   output logic [31:0] o_mem_row_col,
   // unpacked instruction stream
   output logic o_instr_vld,
   output logic [15:0] o_instr_slot
);
   initial begin
      if (NB != 4) $error("decoder serves exactly four banks");
   end

   // ********************************************
   // decode functions
   // ********************************************
   function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction : in_rng

   // window of bank b; async windows are sparse and never remapped
   function automatic logic hit_bank(input logic [31:0] a, input int b, input logic sd);
      logic r;
      r = 1'b0;
      unique case (b)
         0: r = sd ? in_rng(a, ext_port_pkg::SD_B0_LO, ext_port_pkg::SD_B0_HI)
                   : in_rng(a, ext_port_pkg::AS_B0_LO, ext_port_pkg::AS_B0_HI);
         1: r = sd ? in_rng(a, ext_port_pkg::SD_B1_LO, ext_port_pkg::SD_B1_HI)
                   : in_rng(a, ext_port_pkg::AS_B1_LO, ext_port_pkg::AS_B1_HI);
         2: r = sd ? in_rng(a, ext_port_pkg::SD_B2_LO, ext_port_pkg::SD_B2_HI)
                   : in_rng(a, ext_port_pkg::AS_B2_LO, ext_port_pkg::AS_B2_HI);
         default: r = sd ? in_rng(a, ext_port_pkg::SD_B3_LO, ext_port_pkg::SD_B3_HI)
                         : in_rng(a, ext_port_pkg::AS_B3_LO, ext_port_pkg::AS_B3_HI);
      endcase
      hit_bank = r;
   endfunction : hit_bank

   // ********************************************
   // state
   // ********************************************
   typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_WAIT_DATA, ST_UNPACK} phase_t;

   typedef struct packed {
      phase_t phase;
      logic [NB-1:0] sel_n;
      logic [31:0] row_col;
      logic ack;
      logic err;
      logic fetch;
      logic [47:0] word;
      logic [1:0] slot;
      logic ivld;
      logic [15:0] islot;
   } dec_state_t;

   dec_state_t st_ff;
   dec_state_t nxt_st;

   // ********************************************
   // combinational decode of the current request
   // ********************************************
   logic [NB-1:0] hit; // one-hot bank hit
   logic any_hit; // address lands in some window
   logic [1:0] bank_idx; // encoded bank
   logic fetch_ok; // fetch lies inside the allowed window
   logic width_ok; // device width is supported
   logic [TW-1:0] acc_count; // spacing for this access
   logic tim_start; // launches the access timer
   logic tim_busy; // timer running
   logic tim_done; // access spacing elapsed

   generate
      for (genvar g = 0; g < NB; g++) begin : g_hit
         assign hit[g] = hit_bank(i_req_addr, g, i_bank_is_sdram[g]);
      end
   endgenerate

   // lowest hit wins; windows never overlap, so at most one bit is set
   always_comb begin
      any_hit = |hit;
      bank_idx = 2'h0;
      for (int k = NB - 1; k >= 0; k--) begin
         if (hit[k]) bank_idx = 2'(k);
      end
   end

   // fetch only from bank 0, by mode window
   // the bank 0 hit is required too, so a fetch never raises another select
   always_comb begin
      if (i_compressed_instruction_mode) begin
         fetch_ok = hit[0] && in_rng(i_req_addr, ext_port_pkg::SW_FETCH_LO, ext_port_pkg::SW_FETCH_HI);
      end else begin
         fetch_ok = hit[0] && in_rng(i_req_addr, ext_port_pkg::NW_FETCH_LO, ext_port_pkg::NW_FETCH_HI);
      end
   end

   assign width_ok = (i_bank_dev_width[bank_idx*2 +: 2] != ext_port_pkg::DEV_W32);

   // sdram gap or own bank async wait
   assign acc_count = i_bank_is_sdram[bank_idx] ? i_sdram_cmd_gap : i_async_wait[bank_idx*TW +: TW];

   // row and column split from size code; trade-off: no bank-interleave bits
   function automatic logic [31:0] mux_addr(input logic [31:0] a, input logic [2:0] code);
      logic [2:0] c;
      int unsigned cb;
      c = (code > ext_port_pkg::SD_SIZE_MAX) ? ext_port_pkg::SD_SIZE_MAX : code;
      cb = ext_port_pkg::COL_BASE + int'(c >> 1);
      // row keeps 16 bits on purpose; higher row bits of large devices wrap
      mux_addr = {16'(a >> cb), 16'h0000} | (a & ((32'h1 << cb) - 32'h1));
   endfunction : mux_addr

   // ********************************************
   // access spacing timer
   // ********************************************
   // one shared timer is enough, since only one access is ever in flight
   ext_cycle_timer #(.W(TW)) u_timer (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_start(tim_start),
      .i_count(acc_count),
      .o_busy(tim_busy),
      .o_done(tim_done)
   );

   // ********************************************
   // next state
   // ********************************************
   // refusal reasons are merged; o_err does not tell which check failed
   logic req_good; // request accepted
   always_comb begin
      req_good = any_hit && width_ok && (!i_req_fetch || fetch_ok);
      tim_start = 1'b0;
      nxt_st = st_ff;
      nxt_st.ack = 1'b0;
      nxt_st.err = 1'b0;
      nxt_st.ivld = 1'b0;
      unique case (st_ff.phase)
         ST_IDLE: begin
            // a request outside idle is ignored; the requester holds it or pulses again
            if (i_req) begin
               if (req_good) begin
                  nxt_st.sel_n = ~hit;
                  nxt_st.row_col = i_bank_is_sdram[bank_idx]
                     ? mux_addr(i_req_addr, i_sdram_size[bank_idx*3 +: 3]) : i_req_addr;
                  nxt_st.fetch = i_req_fetch;
                  nxt_st.phase = ST_ACCESS;
                  tim_start = 1'b1;
               end else begin
                  nxt_st.err = 1'b1;
               end
            end
         end
         ST_ACCESS: begin
            if (tim_done) begin
               // select drops before the fetch word returns, so the bus is free while unpacking
               nxt_st.sel_n = '1;
               if (st_ff.fetch && i_compressed_instruction_mode) begin
                  nxt_st.phase = ST_WAIT_DATA;
               end else begin
                  nxt_st.ack = 1'b1;
                  nxt_st.phase = ST_IDLE;
               end
            end
         end
         ST_WAIT_DATA: begin
            if (i_fetch_data_vld) begin
               nxt_st.word = i_fetch_data;
               nxt_st.slot = 2'h0;
               nxt_st.phase = ST_UNPACK;
            end
         end
         ST_UNPACK: begin
            // hand out three slots from one fetch
            nxt_st.ivld = 1'b1;
            nxt_st.islot = st_ff.word[st_ff.slot*ext_port_pkg::SLOT_W +: ext_port_pkg::SLOT_W];
            nxt_st.slot = st_ff.slot + 2'h1;
            if (st_ff.slot == ext_port_pkg::SLOTS_PER_WORD - 2'h1) begin
               nxt_st.ack = 1'b1;
               nxt_st.phase = ST_IDLE;
            end
         end
         // unreachable with four legal phases; kept as a safe return
         default: nxt_st.phase = ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         st_ff <= '{phase: ST_IDLE, sel_n: '1, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_ack = st_ff.ack;
   assign o_err = st_ff.err;
   assign o_bank_select_n = st_ff.sel_n;
   assign o_mem_row_col = st_ff.row_col;
   assign o_instr_vld = st_ff.ivld;
   assign o_instr_slot = st_ff.islot;

   // ********************************************
   // assertions
   // ********************************************
   sequence s_bad_req;
      i_req && st_ff.phase == ST_IDLE && !req_good;
   endsequence

   sequence s_good_req;
      i_req && st_ff.phase == ST_IDLE && req_good;
   endsequence

   select_onehot_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      $countones(~o_bank_select_n) <= 1) else $error("more than one bank select active");
   unmapped_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      s_bad_req |=> o_err && o_bank_select_n == '1) else $error("unmapped access drove a select");
   fetch_bank0_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      s_good_req and (i_req_fetch) |=> o_bank_select_n == 4'he) else $error("fetch outside bank 0");
   nw_window_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      s_good_req and (i_req_fetch && !i_compressed_instruction_mode) |-> i_req_addr <= ext_port_pkg::NW_FETCH_HI)
      else $error("normal fetch beyond window");
   sw_window_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      s_good_req and (i_req_fetch && i_compressed_instruction_mode) |-> i_req_addr >= ext_port_pkg::SW_FETCH_LO)
      else $error("short-word fetch below window");
   width_refuse_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_req && st_ff.phase == ST_IDLE && !width_ok |=> o_err) else $error("32-bit device accepted");
   unpack_three_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      st_ff.phase == ST_WAIT_DATA && i_fetch_data_vld |=> ##1 o_instr_vld [*3] ##0 o_ack)
      else $error("fetch word not unpacked into three slots");
   spacing_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      s_good_req and (!i_req_fetch && acc_count == 4'h2) |=> !o_bank_select_n[bank_idx] [*4])
      else $error("access spacing does not follow bank timing");
   sd_window_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_bank_is_sdram[1] && i_req_addr[31:26] == 6'h01 |-> hit[1]) else $error("sdram bank 1 window wrong");
   async_window_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      !i_bank_is_sdram[1] && i_req_addr == 32'h0480_0000 |-> !any_hit) else $error("async window remapped");
   // window ends, idle quiet and hold counts; fixed counts match a gap of four
   sd_b0_window_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_bank_is_sdram[0] && i_req_addr == ext_port_pkg::SD_B0_HI |-> hit[0])
      else $error("sdram bank 0 window end wrong");
   async_b1_base_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      !i_bank_is_sdram[1] && i_req_addr == ext_port_pkg::AS_B1_LO |-> hit[1])
      else $error("async bank 1 base missed");
   idle_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      st_ff.phase == ST_IDLE |-> o_bank_select_n == '1)
      else $error("select active while idle");
   err_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_err |-> !o_ack && o_bank_select_n == '1)
      else $error("refused access drove a cycle");
   sd_gap_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      s_good_req and (i_bank_is_sdram[bank_idx] && !i_req_fetch && i_sdram_cmd_gap == 4'h4)
      |=> !o_bank_select_n[bank_idx] [*6] ##1 o_ack) else $error("sdram command gap not applied");
   async_raw_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      s_good_req and (!i_bank_is_sdram[bank_idx]) |=> o_mem_row_col == $past(i_req_addr))
      else $error("async address not passed as normal word");

endmodule : ext_port_bank_decoder

// [logic/ext_port_pkg.sv]
// package: address map, widths and encodings of the external port bank decoder
package ext_port_pkg;

   // ********************************************
   // bank count and address width
   // ********************************************
   localparam int unsigned NUM_BANKS = 4;
   localparam int unsigned ADDR_W = 32;

   // ********************************************
   // instruction fetch windows, bank 0 only
   // ********************************************
   localparam logic [31:0] NW_FETCH_LO = 32'h0020_0000;
   localparam logic [31:0] NW_FETCH_HI = 32'h005f_ffff;
   localparam logic [31:0] SW_FETCH_LO = 32'h0060_0000;
   localparam logic [31:0] SW_FETCH_HI = 32'h00ff_ffff;

   // ********************************************
   // sync dram windows
   // ********************************************
   localparam logic [31:0] SD_B0_LO = 32'h0020_0000;
   localparam logic [31:0] SD_B0_HI = 32'h03ff_ffff;
   localparam logic [31:0] SD_B1_LO = 32'h0400_0000;
   localparam logic [31:0] SD_B1_HI = 32'h07ff_ffff;
   localparam logic [31:0] SD_B2_LO = 32'h0800_0000;
   localparam logic [31:0] SD_B2_HI = 32'h0bff_ffff;
   localparam logic [31:0] SD_B3_LO = 32'h0c00_0000;
   localparam logic [31:0] SD_B3_HI = 32'h0fff_ffff;

   // ********************************************
   // async windows
   // ********************************************
   localparam logic [31:0] AS_B0_LO = 32'h0020_0000;
   localparam logic [31:0] AS_B0_HI = 32'h007f_ffff;
   localparam logic [31:0] AS_B1_LO = 32'h0400_0000;
   localparam logic [31:0] AS_B1_HI = 32'h047f_ffff;
   localparam logic [31:0] AS_B2_LO = 32'h0800_0000;
   localparam logic [31:0] AS_B2_HI = 32'h087f_ffff;
   localparam logic [31:0] AS_B3_LO = 32'h0c00_0000;
   localparam logic [31:0] AS_B3_HI = 32'h0c7f_ffff;

   // ********************************************
   // device width and size encodings
   // ********************************************
   localparam logic [1:0] DEV_W8 = 2'h0;
   localparam logic [1:0] DEV_W16 = 2'h1;
   localparam logic [1:0] DEV_W32 = 2'h2;
   // sdram size code: 0=4MB .. 6=256MB, column bits = 8 + code/2
   localparam logic [2:0] SD_SIZE_MAX = 3'h6;
   localparam int unsigned COL_BASE = 8;

   // ********************************************
   // timing field and packing widths
   // ********************************************
   localparam int unsigned TIM_W = 4;
   localparam int unsigned INSTR_W = 48;
   localparam int unsigned SLOT_W = 16;
   localparam logic [1:0] SLOTS_PER_WORD = 2'h3;

endpackage : ext_port_pkg

// [logic/ext_cycle_timer.sv]
// file: cycle timer that spaces one external access by a programmed count
`timescale 1ns/1ps
module ext_cycle_timer #(
   parameter int unsigned W = 4
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // control
   input wire logic i_start,
   input wire logic [W-1:0] i_count,
   // status
   output logic o_busy,
   output logic o_done
);
   initial begin
      if (W < 1 || W > 16) $error("cycle timer width out of range");
   end

   typedef struct packed {
      logic [W-1:0] cnt;
      logic busy;
      logic done;
   } tim_state_t;

   tim_state_t st_ff;
   tim_state_t nxt_st;

   // next state: load on start, count down, pulse done at zero
   always_comb begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      if (!st_ff.busy && i_start) begin
         nxt_st.busy = 1'b1;
         nxt_st.cnt = i_count;
      end else if (st_ff.busy) begin
         if (st_ff.cnt == '0) begin
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_busy = st_ff.busy;
   assign o_done = st_ff.done;

endmodule : ext_cycle_timer

// [tb/ext_mem_model.sv]
// partner model: external memory that returns one fetch word after each bank 0 cycle in compressed instruction mode
`timescale 1ns/1ps
module ext_mem_model #(
   parameter logic [47:0] WORD = 48'h0
) (
   // clock
   input wire logic i_core_clk,
   // select and mode seen from the decoder
   input wire logic i_bank0_select_n,
   input wire logic i_compressed_instruction_mode,
   input wire logic [3:0] i_delay,
   // fetch word back to the decoder
   output logic o_fetch_data_vld,
   output logic [47:0] o_fetch_data
);
   logic sel_d_ff; // select of the previous cycle
   logic [3:0] cnt_ff; // cycles left before the word
   // defined levels at time zero
   initial begin
      sel_d_ff = 1'h1;
      cnt_ff = 4'h0;
      o_fetch_data_vld = 1'h0;
      o_fetch_data = ~WORD;
   end
   // lines toggle when idle so a stale word is never mistaken for fresh data
   always @(posedge i_core_clk) begin
      sel_d_ff <= i_bank0_select_n;
      o_fetch_data_vld <= 1'h0;
      o_fetch_data <= ~o_fetch_data;
      // slow or prompt answer, set by the bench
      if (i_bank0_select_n && !sel_d_ff && i_compressed_instruction_mode) begin
         cnt_ff <= i_delay;
      end else if (cnt_ff == 4'h1) begin
         cnt_ff <= 4'h0;
         // whole 48-bit word in one beat
         o_fetch_data_vld <= 1'h1;
         o_fetch_data <= WORD;
      end else if (cnt_ff != 4'h0) begin
         cnt_ff <= cnt_ff - 4'h1;
      end
   end
endmodule : ext_mem_model

// [tb/ext_port_bank_decoder_bench.sv]
// testbench: directed scenarios for the external port bank decoder
`timescale 1ns/1ps
module ext_port_bank_decoder_bench;
   // ********************************************
   // signals
   // ********************************************
   localparam logic [47:0] WORD = 48'h9a4c_3e17_d25b; // fetch word of the model
   logic i_core_clk = 1'h0;
   logic i_rst_n = 1'h0;
   logic [3:0] sdram = 4'h0; // bank kind
   logic [7:0] dev_w = 8'h55; // all banks 16-bit
   logic [11:0] sz = 12'h030; // bank1 256MB, others 4MB
   logic [15:0] wait_n = 16'h1523; // async holds 3,2,5,1
   logic [3:0] gap = 4'h4; // sdram hold
   logic cmode = 1'h0;
   logic req = 1'h0;
   logic fetch = 1'h0;
   logic [31:0] addr = 32'h0;
   logic [3:0] mdly = 4'h1; // model answer delay
   logic fvld;
   logic [47:0] fdata;
   logic ack;
   logic err;
   logic ivld;
   logic [3:0] sel_n;
   logic [31:0] row_col;
   logic [15:0] slot;
   int num_errors = 0;
   int checked = 0;
   // free-running core clock, 25 ns
   initial forever #12.5 i_core_clk = ~i_core_clk;
   ext_port_bank_decoder uut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_bank_is_sdram(sdram),
      .i_bank_dev_width(dev_w), .i_sdram_size(sz), .i_async_wait(wait_n), .i_sdram_cmd_gap(gap),
      .i_compressed_instruction_mode(cmode), .i_req(req), .i_req_fetch(fetch), .i_req_addr(addr),
      .i_fetch_data_vld(fvld), .i_fetch_data(fdata), .o_ack(ack), .o_err(err),
      .o_bank_select_n(sel_n), .o_mem_row_col(row_col), .o_instr_vld(ivld), .o_instr_slot(slot));
   ext_mem_model #(.WORD(WORD)) mem (.i_core_clk(i_core_clk), .i_bank0_select_n(sel_n[0]),
      .i_compressed_instruction_mode(cmode), .i_delay(mdly), .o_fetch_data_vld(fvld),
      .o_fetch_data(fdata));
   // ********************************************
   // shared tasks
   // ********************************************
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   // three slots low first, ack with the last; bounded wait for the first
   task automatic unpack();
      int i;
      for (i = 0; i < 16 && ivld !== 1'h1; i++) begin
         @(posedge i_core_clk);
         #1;
      end
      if (ivld !== 1'h1) begin
         num_errors++;
         finish_test();
      end else begin
         check(slot, WORD[15:0]);
         check(ack, 1'h0);
         @(posedge i_core_clk);
         #1;
         check(ivld, 1'h1);
         check(slot, WORD[31:16]);
         @(posedge i_core_clk);
         #1;
         check(slot, WORD[47:32]);
         check(ack, 1'h1);
      end
   endtask : unpack
   // one request pulsed in idle; n = hold count, negative when refused
   task automatic access(input logic [31:0] a, input logic f, input logic [3:0] sel, input int n);
      int i;
      @(posedge i_core_clk);
      req <= 1'h1;
      addr <= a;
      fetch <= f;
      @(posedge i_core_clk);
      req <= 1'h0;
      #1;
      // refusal answers in the one cycle right after the take edge
      check(sel_n, sel);
      if (n < 0) check(err, 1'h1);
      else check(err, 1'h0);
      for (i = 0; i <= n; i++) begin
         @(posedge i_core_clk);
         #1;
         check(sel_n, sel);
         check(ack, 1'h0);
      end
      @(posedge i_core_clk);
      #1;
      check(sel_n, 4'hf);
      if (n < 0) check(err, 1'h0);
      else if (f && cmode) unpack();
      else check(ack, 1'h1);
   endtask : access
   // ********************************************
   // scenarios
   // ********************************************
   task automatic t_async();
      sdram <= 4'h0;
      access(32'h0400_0010, 1'h0, 4'hd, 2);
      check(row_col, 32'h0400_0010);
      access(32'h0800_0000, 1'h0, 4'hb, 5);
      access(32'h0c7f_ffff, 1'h0, 4'h7, 1);
      access(32'h007f_ffff, 1'h0, 4'he, 3);
      check(row_col, 32'h007f_ffff);
      access(32'h0080_0000, 1'h0, 4'hf, -1);
      access(32'h0480_0000, 1'h0, 4'hf, -1);
      access(32'h001f_ffff, 1'h0, 4'hf, -1);
      access(32'h1000_0000, 1'h0, 4'hf, -1);
   endtask : t_async
   task automatic t_sdram();
      sdram <= 4'hf;
      access(32'h03ff_ffff, 1'h0, 4'he, 4);
      access(32'h0400_0abc, 1'h0, 4'hd, 4);
      check(row_col, 32'h8001_02bc);
      access(32'h0800_00cd, 1'h0, 4'hb, 4);
      check(row_col, 32'h0000_00cd);
      access(32'h0fff_ffff, 1'h0, 4'h7, 4);
      access(32'h001f_ffff, 1'h0, 4'hf, -1);
      gap <= 4'h1;
      access(32'h0c00_0000, 1'h0, 4'h7, 1);
      gap <= 4'h4;
   endtask : t_sdram
   task automatic t_width();
      dev_w <= 8'h09; // bank1 32-bit, bank2 8-bit
      access(32'h0400_0000, 1'h0, 4'hf, -1);
      sdram <= 4'h0;
      access(32'h0400_0000, 1'h0, 4'hf, -1);
      access(32'h0800_0000, 1'h0, 4'hb, 5);
      dev_w <= 8'h55;
   endtask : t_width
   task automatic t_fetch();
      sdram <= 4'h1;
      cmode <= 1'h0;
      access(32'h005f_ffff, 1'h1, 4'he, 4);
      access(32'h0060_0000, 1'h1, 4'hf, -1);
      access(32'h0400_0000, 1'h1, 4'hf, -1);
      cmode <= 1'h1;
      access(32'h005f_ffff, 1'h1, 4'hf, -1);
      access(32'h0100_0000, 1'h1, 4'hf, -1);
      access(32'h0800_0000, 1'h1, 4'hf, -1);
      access(32'h0060_0000, 1'h1, 4'he, 4);
      mdly <= 4'h6;
      access(32'h00ff_ffff, 1'h1, 4'he, 4);
      cmode <= 1'h0;
   endtask : t_fetch
   // main sequence: reset two cycles, then every scenario
   initial begin
      repeat (2) @(posedge i_core_clk);
      i_rst_n <= 1'h1;
      #1;
      check(sel_n, 4'hf);
      check(ack, 1'h0);
      check(ivld, 1'h0);
      t_async();
      t_sdram();
      t_width();
      t_fetch();
      finish_test();
   end
endmodule : ext_port_bank_decoder_bench
